/* shared/sidesc_pkg.sv */
// Package: constants and carriers for the split interrupt descriptor engine
package sidesc_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W   = 7;
  localparam int EP_W     = 4;
  localparam int MPS_W    = 11;
  localparam int TBC_W    = 15;
  localparam int SCHED_W  = 8;
  localparam int UFRAME_W = 16;
  localparam int RATE_LSB = 3;  // Polling rate field starts at schedule bit 3
  localparam int RATE_W   = 5;
  localparam int SHIFT_W  = 3;

  // ==========================================================================
  // Limits and encodings
  localparam logic [MPS_W-1:0]    FS_LS_MAX_PACKET   = 11'h040;
  localparam logic [TBC_W-1:0]    MAX_TRANSFER_BYTES = 15'h1000;
  localparam logic [1:0]          KIND_INTERRUPT     = 2'h3;
  localparam logic [1:0]          TOKEN_OUT          = 2'h0;
  localparam logic [1:0]          TOKEN_IN           = 2'h1;
  localparam logic [1:0]          SPEED_END_NONE     = 2'h0;
  localparam logic [UFRAME_W-1:0] BASE_PERIOD        = 16'h0008;
  localparam logic [SHIFT_W-1:0]  SHIFT_ONE          = 3'h1;

  // ==========================================================================
  // Low 64-bit word of the transfer descriptor, bit 63 down to bit 0
  typedef struct packed {
    logic [6:0]       hub_addr;             // 63:57
    logic [6:0]       hub_port;             // 56:50
    logic [1:0]       speed_end_select;     // 49:48
    logic             rsvd_47;              // 47
    logic             split;                // 46
    logic [1:0]       endpoint_kind;        // 45:44
    logic [1:0]       token;                // 43:42
    logic [ADDR_W-1:0] function_addr;       // 41:35
    logic [2:0]       endpoint_number_hi;   // 34:32
    logic             endpoint_number_lo;   // 31
    logic [1:0]       rsvd_30;              // 30:29
    logic [MPS_W-1:0] max_packet_size;      // 28:18
    logic [TBC_W-1:0] transfer_byte_count;  // 17:3
    logic [1:0]       rsvd_2;               // 2:1
    logic             valid;                // 0
  } sidesc_desc_type;

  // Token request handed to the link engine
  typedef struct packed {
    logic              split;
    logic [1:0]        speed_end_select;
    logic [6:0]        hub_addr;
    logic [6:0]        hub_port;
    logic [1:0]        token;
    logic [ADDR_W-1:0] function_addr;
    logic [EP_W-1:0]   endpoint_number;
    logic [MPS_W-1:0]  byte_count;
  } sidesc_token_type;

  typedef enum logic [0:0] {
    SIDESC_IDLE  = 1'b0,
    SIDESC_ISSUE = 1'b1
  } sidesc_state_type;

endpackage : sidesc_pkg

/* rtl/sidesc_engine.sv */
// Module: split interrupt transfer descriptor scheduler and executor
// Function
// - Tokens carry seven-bit function address field
// - Endpoint number built from two split fields
// - Packet bytes limited, 64 for split
// - Transfer byte count limited to 4 kB
// - Valid cleared on completion or fatal error
// - Speed/end field applies only to splits
// - Polling period is 2^(b-1) microframes
`timescale 1ns/10ps

module sidesc_engine (
  input  wire logic                                core_clk,
  input  wire logic                                nrst,
  input  wire logic                                uframe_tick,
  input  wire logic                                desc_write,
  input  wire sidesc_pkg::sidesc_desc_type         desc_in,
  input  wire logic [sidesc_pkg::SCHED_W-1:0]      sched_in,
  input  wire logic                                active_in,
  output logic                                     tok_req,
  output sidesc_pkg::sidesc_token_type             tok,
  input  wire logic                                rsp_done,
  input  wire logic [sidesc_pkg::MPS_W-1:0]        rsp_bytes,
  input  wire logic                                rsp_fatal,
  output logic                                     desc_valid,
  output logic                                     desc_active,
  output logic                                     fatal_seen,
  output logic [sidesc_pkg::TBC_W-1:0]             bytes_remaining
);

  // ==========================================================================
  // Storage
  sidesc_pkg::sidesc_desc_type           desc;
  logic [sidesc_pkg::SCHED_W-1:0]        sched;
  logic [sidesc_pkg::UFRAME_W-1:0]       uframe_cnt;
  sidesc_pkg::sidesc_state_type          state;
  logic [sidesc_pkg::UFRAME_W-1:0]       period;
  logic [sidesc_pkg::MPS_W-1:0]          mps_eff;
  logic [sidesc_pkg::MPS_W-1:0]          next_pkt;
  logic                                  slot_hit;
  logic                                  issue;
  logic                                  finish;
  logic                                  last_pkt;

  // ==========================================================================
  // Polling period from the rate field: highest set bit picks b
  always_comb begin
    logic [sidesc_pkg::RATE_W-1:0] rate;
    rate   = sched[sidesc_pkg::RATE_LSB +: sidesc_pkg::RATE_W];
    period = sidesc_pkg::BASE_PERIOD;  // b = 4, every millisecond
    for (int i = 0; i < sidesc_pkg::RATE_W; i++) begin
      if (rate[i]) begin
        period = sidesc_pkg::BASE_PERIOD << (i + 1);
      end
    end
  end

  // Slot match and issue decision
  assign slot_hit = ((uframe_cnt & (period - 16'h0001)) == '0);
  assign issue    = (state == sidesc_pkg::SIDESC_IDLE) && uframe_tick &&
                    slot_hit && desc_valid && !desc_write;

  // Packet size: clamp to the full/low-speed ceiling on splits
  always_comb begin
    mps_eff = desc.max_packet_size;
    if (desc.split && (mps_eff > sidesc_pkg::FS_LS_MAX_PACKET)) begin
      mps_eff = sidesc_pkg::FS_LS_MAX_PACKET;
    end
    if (bytes_remaining < {4'h0, mps_eff}) begin
      next_pkt = bytes_remaining[sidesc_pkg::MPS_W-1:0];
    end else begin
      next_pkt = mps_eff;
    end
  end

  // Completion: short packet or nothing left
  assign last_pkt = (rsp_bytes < tok.byte_count) ||
                    ({4'h0, rsp_bytes} >= bytes_remaining);
  assign finish   = (state == sidesc_pkg::SIDESC_ISSUE) && rsp_done &&
                    (rsp_fatal || last_pkt);

  // ==========================================================================
  // Microframe counter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      uframe_cnt <= '0;
    end else if (uframe_tick) begin
      uframe_cnt <= uframe_cnt + 16'h0001;
    end
  end

  // Descriptor store; a software write wins over a hardware clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      desc  <= '0;
      sched <= '0;
    end else if (desc_write) begin
      desc  <= desc_in;
      sched <= sched_in;
    end else if (finish) begin
      desc.valid <= 1'b0;
    end
  end

  // Valid and active flags seen by software
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      desc_valid  <= 1'b0;
      desc_active <= 1'b0;
    end else if (desc_write) begin
      desc_valid  <= desc_in.valid;
      desc_active <= active_in;
    end else if (finish) begin
      desc_valid  <= 1'b0;
      desc_active <= 1'b0;
    end
  end

  // Fatal error flag, set on a fatal answer, cleared by a new descriptor
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fatal_seen <= 1'b0;
    end else if (state == sidesc_pkg::SIDESC_ISSUE && rsp_done &&
                 rsp_fatal) begin
      fatal_seen <= 1'b1;
    end else if (desc_write) begin
      fatal_seen <= 1'b0;
    end
  end

  // Remaining payload, clamped to 4 kB on load
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bytes_remaining <= '0;
    end else if (desc_write) begin
      if (desc_in.transfer_byte_count > sidesc_pkg::MAX_TRANSFER_BYTES) begin
        bytes_remaining <= sidesc_pkg::MAX_TRANSFER_BYTES;
      end else begin
        bytes_remaining <= desc_in.transfer_byte_count;
      end
    end else if (state == sidesc_pkg::SIDESC_ISSUE && rsp_done &&
                 !rsp_fatal) begin
      if (last_pkt) begin
        bytes_remaining <= '0;
      end else begin
        bytes_remaining <= bytes_remaining - {4'h0, rsp_bytes};
      end
    end
  end

  // ==========================================================================
  // Scheduler state and token request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state   <= sidesc_pkg::SIDESC_IDLE;
      tok_req <= 1'b0;
    end else begin
      unique case (state)
        sidesc_pkg::SIDESC_IDLE: begin
          if (issue) begin
            state   <= sidesc_pkg::SIDESC_ISSUE;
            tok_req <= 1'b1;
          end
        end
        sidesc_pkg::SIDESC_ISSUE: begin
          if (rsp_done) begin
            state   <= sidesc_pkg::SIDESC_IDLE;
            tok_req <= 1'b0;
          end
        end
      endcase
    end
  end

  // Token fields captured at issue
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tok <= '0;
    end else if (issue) begin
      tok.split            <= desc.split;
      tok.speed_end_select <= desc.split ? desc.speed_end_select :
                              sidesc_pkg::SPEED_END_NONE;
      tok.hub_addr         <= desc.hub_addr;
      tok.hub_port         <= desc.hub_port;
      tok.token            <= desc.token;
      tok.function_addr    <= desc.function_addr;
      tok.endpoint_number  <= {desc.endpoint_number_hi,
                               desc.endpoint_number_lo};
      tok.byte_count       <= next_pkt;
    end
  end

  // ==========================================================================
  // Checks
  chk_addr_field: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(tok_req) |-> tok.function_addr == $past(desc.function_addr))
    else $error("token address differs from descriptor");

  chk_endp_field: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(tok_req) |-> tok.endpoint_number ==
      {$past(desc.endpoint_number_hi), $past(desc.endpoint_number_lo)})
    else $error("token endpoint differs from descriptor");

  chk_split_packet: assert property (
    @(posedge core_clk) disable iff (!nrst)
    tok_req && tok.split |-> tok.byte_count <= sidesc_pkg::FS_LS_MAX_PACKET)
    else $error("split packet above 64 bytes");

  chk_mps_packet: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(tok_req) |-> tok.byte_count <= $past(desc.max_packet_size))
    else $error("packet above maximum packet size");

  chk_xfer_limit: assert property (
    @(posedge core_clk) disable iff (!nrst)
    bytes_remaining <= sidesc_pkg::MAX_TRANSFER_BYTES)
    else $error("transfer count above 4 kB");

  chk_fatal_clear: assert property (
    @(posedge core_clk) disable iff (!nrst)
    state == sidesc_pkg::SIDESC_ISSUE && rsp_done && rsp_fatal && !desc_write
    |=> !desc_valid && !desc_active && fatal_seen)
    else $error("valid not cleared after fatal error");

  chk_done_clear: assert property (
    @(posedge core_clk) disable iff (!nrst)
    state == sidesc_pkg::SIDESC_ISSUE && rsp_done && !desc_write &&
    (({4'h0, rsp_bytes} >= bytes_remaining)) |=> !desc_valid)
    else $error("valid not cleared after last packet");

  chk_speed_end: assert property (
    @(posedge core_clk) disable iff (!nrst)
    tok_req && !tok.split |->
      tok.speed_end_select == sidesc_pkg::SPEED_END_NONE)
    else $error("speed/end on non-split token");

  chk_poll_slot: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(tok_req) |-> $past(uframe_tick) && $past(slot_hit))
    else $error("token issued outside polling slot");

  chk_skip_invalid: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(tok_req) |-> $past(desc_valid))
    else $error("token issued for invalid descriptor");

  cov_split_in: cover property (@(posedge core_clk) disable iff (!nrst)
    $rose(tok_req) && tok.split && tok.token == sidesc_pkg::TOKEN_IN);

  cov_fatal: cover property (@(posedge core_clk) disable iff (!nrst)
    $rose(fatal_seen));

  cov_multi_pkt: cover property (@(posedge core_clk) disable iff (!nrst)
    $fell(tok_req) && desc_valid);

endmodule : sidesc_engine

/* tb/sidesc_link_model.sv */
// Link engine model answering token requests from the engine
`timescale 1ns/10ps

module sidesc_link_model (
  input  wire logic                         core_clk,
  input  wire logic                         nrst,
  input  wire logic                         tok_req,
  input  wire sidesc_pkg::sidesc_token_type tok,
  input  wire logic [3:0]                   dly,
  input  wire logic [10:0]                  short_by,
  input  wire logic                         fatal_cmd,
  output logic                              rsp_done,
  output logic [10:0]                       rsp_bytes,
  output logic                              rsp_fatal
);
  // ==========================================================================
  // Answer
  logic [3:0] cnt;

  // Answer after dly cycles; between answers the data lines toggle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt       <= 4'h0;
      rsp_done  <= 1'b0;
      rsp_bytes <= 11'h000;
      rsp_fatal <= 1'b0;
    end else if (tok_req && !rsp_done && cnt == dly) begin
      cnt       <= 4'h0;
      rsp_done  <= 1'b1;
      rsp_bytes <= tok.byte_count - short_by;
      rsp_fatal <= fatal_cmd;
    end else begin
      cnt       <= (tok_req && !rsp_done) ? cnt + 4'h1 : 4'h0;
      rsp_done  <= 1'b0;
      rsp_bytes <= ~rsp_bytes;
      rsp_fatal <= ~rsp_fatal;
    end
  end
endmodule : sidesc_link_model

/* tb/sidesc_engine_tb.sv */
// Self-checking bench for the descriptor engine
`timescale 1ns/10ps

module sidesc_engine_tb;
  // ==========================================================================
  // Signals
  logic core_clk, nrst, desc_write, active_in, tok_req, fatal_cmd;
  logic uframe_tick = 1'b0;
  logic rsp_done, rsp_fatal, desc_valid, desc_active, fatal_seen;
  logic [7:0]  sched_in;
  logic [3:0]  dly;
  logic [10:0] short_by, rsp_bytes;
  logic [14:0] bytes_remaining;
  sidesc_pkg::sidesc_desc_type  desc_in, cur;
  sidesc_pkg::sidesc_token_type tok;
  logic [4:0] pats [6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F};
  int fails, check_count, ticks, tick_at, t0, ph, n;

  sidesc_engine uut (.core_clk(core_clk), .nrst(nrst),
    .uframe_tick(uframe_tick), .desc_write(desc_write), .desc_in(desc_in),
    .sched_in(sched_in), .active_in(active_in), .tok_req(tok_req),
    .tok(tok), .rsp_done(rsp_done), .rsp_bytes(rsp_bytes),
    .rsp_fatal(rsp_fatal), .desc_valid(desc_valid),
    .desc_active(desc_active), .fatal_seen(fatal_seen),
    .bytes_remaining(bytes_remaining));

  sidesc_link_model link (.core_clk(core_clk), .nrst(nrst),
    .tok_req(tok_req), .tok(tok), .dly(dly), .short_by(short_by),
    .fatal_cmd(fatal_cmd), .rsp_done(rsp_done), .rsp_bytes(rsp_bytes),
    .rsp_fatal(rsp_fatal));

  // Clock and a microframe tick every eight cycles
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    #1;
    ph = (ph + 1) % 8;
    uframe_tick = (ph == 0);
    if (ph == 0) ticks++;
  end

  // ==========================================================================
  // Tasks
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string nm, input logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : check

  function automatic sidesc_pkg::sidesc_desc_type mk(input logic s,
      input logic [1:0] tk, input logic [14:0] cnt, input logic v);
    sidesc_pkg::sidesc_desc_type d;
    d = '0;
    d.hub_addr = 7'h12;
    d.hub_port = 7'h03;
    d.speed_end_select = 2'h2;
    d.split = s;
    d.endpoint_kind = sidesc_pkg::KIND_INTERRUPT;
    d.token = tk;
    d.function_addr = 7'h55;
    d.endpoint_number_hi = 3'h5;
    d.endpoint_number_lo = 1'b1;
    d.max_packet_size = 11'h064;
    d.transfer_byte_count = cnt;
    d.valid = v;
    return d;
  endfunction : mk

  // Load a descriptor; active written equal to valid
  task automatic load(input sidesc_pkg::sidesc_desc_type d,
      input logic [7:0] sc);
    cur = d;
    step;
    desc_in = d;
    sched_in = sc;
    active_in = d.valid;
    desc_write = 1'b1;
    step;
    desc_write = 1'b0;
  endtask : load

  // Wait for one token, compare it, wait for its close
  task automatic xfer(input logic [10:0] bc);
    sidesc_pkg::sidesc_token_type e;
    e.split = cur.split;
    e.speed_end_select = cur.split ? cur.speed_end_select : 2'h0;
    e.hub_addr = cur.hub_addr;
    e.hub_port = cur.hub_port;
    e.token = cur.token;
    e.function_addr = cur.function_addr;
    e.endpoint_number = {cur.endpoint_number_hi, cur.endpoint_number_lo};
    e.byte_count = bc;
    n = 0;
    while (tok_req !== 1'b1 && n < 4000) begin
      step;
      n++;
    end
    tick_at = ticks;
    check("token", tok, e);
    while (tok_req !== 1'b0 && n < 4100) begin
      step;
      n++;
    end
    if (n >= 4000) begin
      fails++;
      end_of_test;
    end
  endtask : xfer

  // ==========================================================================
  // Tests
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    desc_write = 1'b0;
    desc_in = '0;
    cur = '0;
    sched_in = 8'h00;
    active_in = 1'b0;
    dly = 4'h1;
    short_by = 11'h000;
    fatal_cmd = 1'b0;
    fails = 0;
    check_count = 0;
    ticks = 0;
    ph = 0;
    repeat (6) @(posedge core_clk);
    #1 nrst = 1;
    // Split IN: packet clamped to 64, then the tail ends it
    load(mk(1'b1, sidesc_pkg::TOKEN_IN, 15'h0064, 1'b1), 8'h00);
    xfer(11'h040);
    check("remaining", bytes_remaining, 15'h0024);
    check("active", desc_active, 1'b1);
    dly = 4'h4;
    xfer(11'h024);
    check("valid", desc_valid, 1'b0);
    check("active", desc_active, 1'b0);
    $display("test split done");
    // Plain OUT: count clamp and period of every rate pattern
    for (int i = 0; i < 6; i++) begin
      load(mk(1'b0, sidesc_pkg::TOKEN_OUT, 15'h7FFF, 1'b1), {pats[i], 3'h0});
      check("clamp", bytes_remaining, 15'h1000);
      xfer(11'h064);
      t0 = tick_at;
      xfer(11'h064);
      check("period", tick_at - t0, 8 << i);
    end
    $display("test period done");
    // Fatal answer, then a short packet
    fatal_cmd = 1'b1;
    load(mk(1'b1, sidesc_pkg::TOKEN_IN, 15'h0064, 1'b1), 8'h00);
    xfer(11'h040);
    check("valid", desc_valid, 1'b0);
    check("fatal", fatal_seen, 1'b1);
    check("remaining", bytes_remaining, 15'h0064);
    fatal_cmd = 1'b0;
    short_by = 11'h00A;
    load(mk(1'b1, sidesc_pkg::TOKEN_OUT, 15'h0064, 1'b1), 8'h00);
    check("fatal", fatal_seen, 1'b0);
    xfer(11'h040);
    check("valid", desc_valid, 1'b0);
    check("remaining", bytes_remaining, 15'h0000);
    $display("test error done");
    // Invalid descriptor never issues a token
    load(mk(1'b1, sidesc_pkg::TOKEN_IN, 15'h0064, 1'b0), 8'h00);
    n = 0;
    repeat (400) begin
      step;
      if (tok_req !== 1'b0) n++;
    end
    check("no token", n, 0);
    $display("test invalid done");
    end_of_test;
  end
endmodule : sidesc_engine_tb
